//--- src/bcds_pkg.sv
package bcds_pkg;

    // system clock and link timing, nominal figures
    localparam int CLK_PERIOD_NS         = 40;
    localparam int BIT_CLOCK_PERIOD_NS   = 320000;
    localparam int BIT_SETUP_TIME_NS     = 100000;
    localparam int CLOCK_LOW_TIME_NS     = 100000;
    localparam int STROBE_LEAD_TIME_US   = 12000;
    localparam int STROBE_TRAIL_TIME_US  = 12000;

    localparam int BIT_PERIOD_CYC   = BIT_CLOCK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SETUP_CYC        = BIT_SETUP_TIME_NS / CLK_PERIOD_NS;
    localparam int CLK_LOW_CYC      = CLOCK_LOW_TIME_NS / CLK_PERIOD_NS;
    localparam int STROBE_LEAD_CYC  = STROBE_LEAD_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int STROBE_TRAIL_CYC = STROBE_TRAIL_TIME_US * 1000 / CLK_PERIOD_NS;

    localparam int TMR_W  = 20;
    localparam int FAC_W  = 17;
    localparam int USR_W  = 20;
    localparam int DIG_N  = 6;
    localparam int CHAR_BITS = 5;
    localparam int FIFO_DEPTH = 2;

    // character values
    localparam logic [3:0]  CHAR_START   = 4'hB;
    localparam logic [3:0]  CHAR_END     = 4'hF;
    localparam logic [3:0]  SEP_FIRST    = 4'h0;
    localparam logic [3:0]  SEP_SECOND   = 4'h1;
    localparam logic [31:0] CONST_DIGITS = 32'h1A210001;

    // framing per format: zero preamble bits, trailing zero bits, characters
    localparam logic [4:0] PRE_PLAIN   = 5'h00;
    localparam logic [4:0] PRE_LRC     = 5'h0A;
    localparam logic [4:0] PRE_LONG    = 5'h0F;
    localparam logic [4:0] POST_LONG   = 5'h0F;
    localparam logic [4:0] NCHAR_PLAIN = 5'h0C;
    localparam logic [4:0] NCHAR_LRC   = 5'h0D;
    localparam logic [4:0] NCHAR_LONG  = 5'h17;

    typedef enum logic [1:0] {
        BCDS_FMT_PLAIN = 2'h0,
        BCDS_FMT_LRC   = 2'h1,
        BCDS_FMT_LONG  = 2'h2
    } bcds_fmt_e;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_CONV  = 5'h02,
        ST_LEAD  = 5'h04,
        ST_SEND  = 5'h08,
        ST_TRAIL = 5'h10
    } bcds_state_e;

    typedef enum logic [2:0] {
        PH_SETUP = 3'h1,
        PH_LOW   = 3'h2,
        PH_HIGH  = 3'h4
    } bcds_phase_e;

    typedef enum logic [2:0] {
        SEC_PRE  = 3'h1,
        SEC_CHAR = 3'h2,
        SEC_POST = 3'h4
    } bcds_sect_e;

    typedef logic [DIG_N-1:0][3:0] bcds_digs_t;

    typedef struct packed {
        logic [FAC_W-1:0] facility;
        logic [USR_W-1:0] user;
    } bcds_req_s;

    // open-drain enables: high pulls the line low
    typedef struct packed {
        logic strobe_oe;
        logic clk_oe;
        logic data_oe;
    } bcds_link_s;

endpackage : bcds_pkg

//--- src/bcds_serializer.sv
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// [RL1] drive data, clock and card-load strobe lines to the terminal
// [RL2] strobe is optional; disabled means data and clock only
// [RL3] every line is open-drain: pulled low or released, never driven high
// [RL4] all link signals active low; a one bit pulls data low
// [RL5] data set before the falling clock edge and held through it
// [RL6] strobe asserted 12 ms before the first data bit
// [RL7] strobe held 12 ms after the last data bit
// [RL8] bit clock period 320 us with 100 us low phase
// [RL9] each data bit stands 100 us before its clock edge
// [RL10] a character is four value bits, LSB first, then parity
// [RL11] parity bit makes the five-bit count of ones odd
// [RL12] every message starts with character B
// [RL13] message body ends with character F
// [RL14] plain format: start, five facility, five user digits, end
// [RL15] fields sent as decimal, most significant digit first, zero padded
// [RL16] second format: ten zero bits, plain body, then check character
// [RL17] check character covers start through end characters
// [RL18] check value is XOR of character values, sent with own parity
// [RL19] long format: 15 zeros, S, constants, A4, M, N, B6, E, L, 15 zeros
// [RL20] long format constants 1A210001, separators 0 then 1
// [RL21] binary request converted to decimal; busy until strobe released
// [RL22] all lines released between messages and in reset
module bcds_serializer
    import bcds_pkg::*;
#(
    parameter int BIT_PERIOD   = BIT_PERIOD_CYC,
    parameter int STROBE_LEAD  = STROBE_LEAD_CYC,
    parameter int STROBE_TRAIL = STROBE_TRAIL_CYC
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // configuration
    input  wire bcds_fmt_e   cfg_fmt,
    input  wire logic        cfg_strobe_en,
    // message requests
    input  wire logic        req_valid,
    input  wire bcds_req_s   req,
    output logic             req_ready,
    output logic             busy,
    // link pins, open-drain enables
    output bcds_link_s       link
);

    // set-up and low phases scale with the slot, so a shortened slot keeps its shape
    localparam int SETUP_LEN = BIT_PERIOD * SETUP_CYC / BIT_PERIOD_CYC;
    localparam int LOW_LEN   = BIT_PERIOD * CLK_LOW_CYC / BIT_PERIOD_CYC;

    // request buffer
    bcds_req_s   fifo_q [FIFO_DEPTH];
    bcds_req_s   fifo_d [FIFO_DEPTH];
    logic        wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [1:0]  cnt_q, cnt_d;
    logic        ready_q, ready_d;
    logic        push, pop;

    // message engine
    bcds_state_e      state_q, state_d;
    bcds_phase_e      ph_q, ph_d;
    bcds_sect_e       sect_q, sect_d;
    bcds_fmt_e        fmt_q, fmt_d;
    logic             stb_en_q, stb_en_d;
    logic [FAC_W-1:0] fac_q, fac_d;
    logic [USR_W-1:0] usr_q, usr_d;
    bcds_digs_t       fdig_q, fdig_d, udig_q, udig_d;
    logic [2:0]       conv_q, conv_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic [4:0]       zcnt_q, zcnt_d, cidx_q, cidx_d;
    logic [2:0]       bpos_q, bpos_d;
    logic [3:0]       lrc_q, lrc_d;
    bcds_link_s       link_q, link_d;
    logic             busy_q, busy_d;

    logic [3:0]       nib;
    logic [4:0]       chr;
    logic [4:0]       pre_n, post_n, nchar;
    logic [TMR_W-1:0] ph_len;
    logic             cur_bit, slot_end;

    function automatic logic [3:0] char_of(input bcds_fmt_e  f,
                                           input logic [4:0] i,
                                           input bcds_digs_t fd,
                                           input bcds_digs_t ud,
                                           input logic [3:0] l);
        int k;
        logic [3:0] v;
        k = int'(i);
        v = l;
        if (k == 0) begin
            v = CHAR_START;                                        // [RL12]
        end else if (f == BCDS_FMT_LONG) begin
            if (k <= 8) begin
                v = CONST_DIGITS[(8-k)*4 +: 4];                    // [RL20]
            end else if (k <= 12) begin
                v = fd[12-k];                                      // [RL15]
            end else if (k == 13) begin
                v = SEP_FIRST;                                     // [RL20]
            end else if (k == 14) begin
                v = SEP_SECOND;
            end else if (k <= 20) begin
                v = ud[20-k];                                      // [RL19]
            end else if (k == 21) begin
                v = CHAR_END;
            end
        end else begin
            if (k <= 5) begin
                v = fd[5-k];                                       // [RL15]
            end else if (k <= 10) begin
                v = ud[10-k];                                      // [RL14]
            end else if (k == 11) begin
                v = CHAR_END;                                      // [RL13]
            end
        end
        return v;
    endfunction : char_of

    // framing of the selected format
    always_comb begin
        pre_n  = PRE_PLAIN;
        post_n = PRE_PLAIN;
        nchar  = NCHAR_PLAIN;                                      // [RL14]
        unique case (fmt_q)
            BCDS_FMT_LRC: begin
                pre_n = PRE_LRC;                                   // [RL16]
                nchar = NCHAR_LRC;
            end
            BCDS_FMT_LONG: begin
                pre_n  = PRE_LONG;                                 // [RL19]
                post_n = POST_LONG;
                nchar  = NCHAR_LONG;
            end
            default: ;
        endcase
    end

    always_comb begin
        nib = char_of(fmt_q, cidx_q, fdig_q, udig_q, lrc_q);      // [RL18]
        chr = {~^nib, nib};                                        // [RL10] [RL11]
        cur_bit = (sect_q == SEC_CHAR) && chr[bpos_q];
        unique case (ph_q)
            PH_SETUP: ph_len = TMR_W'(SETUP_LEN);                  // [RL9]
            PH_LOW:   ph_len = TMR_W'(LOW_LEN);                    // [RL8]
            default:  ph_len = TMR_W'(BIT_PERIOD - SETUP_LEN - LOW_LEN);
        endcase
        slot_end = (ph_q == PH_HIGH) && (tmr_q == ph_len - 1'b1);
    end

    // request buffer: the engine drains only when idle, so it really fills
    always_comb begin
        push     = req_valid && ready_q;
        fifo_d   = fifo_q;
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        cnt_d    = cnt_q;
        if (push) begin
            fifo_d[wr_ptr_q] = req;
            wr_ptr_d = ~wr_ptr_q;
        end
        if (pop) begin
            rd_ptr_d = ~rd_ptr_q;
        end
        cnt_d   = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        ready_d = (cnt_d != 2'h2);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fifo_q[0] <= '0;
            fifo_q[1] <= '0;
            wr_ptr_q  <= 1'b0;
            rd_ptr_q  <= 1'b0;
            cnt_q     <= 2'h0;
            ready_q   <= 1'b1;
        end else if (clk_en) begin
            fifo_q    <= fifo_d;
            wr_ptr_q  <= wr_ptr_d;
            rd_ptr_q  <= rd_ptr_d;
            cnt_q     <= cnt_d;
            ready_q   <= ready_d;
        end
    end

    // message engine
    always_comb begin
        state_d  = state_q;
        ph_d     = ph_q;
        sect_d   = sect_q;
        fmt_d    = fmt_q;
        stb_en_d = stb_en_q;
        fac_d    = fac_q;
        usr_d    = usr_q;
        fdig_d   = fdig_q;
        udig_d   = udig_q;
        conv_d   = conv_q;
        tmr_d    = tmr_q + 1'b1;
        zcnt_d   = zcnt_q;
        cidx_d   = cidx_q;
        bpos_d   = bpos_q;
        lrc_d    = lrc_q;
        pop      = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (cnt_q != 2'h0) begin
                    pop      = 1'b1;
                    fac_d    = fifo_q[rd_ptr_q].facility;
                    usr_d    = fifo_q[rd_ptr_q].user;
                    fmt_d    = cfg_fmt;
                    stb_en_d = cfg_strobe_en;                      // [RL2]
                    conv_d   = 3'h0;
                    state_d  = ST_CONV;
                end
            end
            ST_CONV: begin
                // one decimal digit per cycle, least significant first
                fdig_d[conv_q] = 4'(fac_q % FAC_W'(10));           // [RL21]
                udig_d[conv_q] = 4'(usr_q % USR_W'(10));
                fac_d  = fac_q / FAC_W'(10);
                usr_d  = usr_q / USR_W'(10);
                conv_d = conv_q + 1'b1;
                tmr_d  = '0;
                ph_d   = PH_SETUP;
                sect_d = (pre_n != 5'h00) ? SEC_PRE : SEC_CHAR;
                zcnt_d = 5'h00;
                cidx_d = 5'h00;
                bpos_d = 3'h0;
                lrc_d  = 4'h0;
                if (conv_q == 3'(DIG_N - 1)) begin
                    state_d = stb_en_q ? ST_LEAD : ST_SEND;
                end
            end
            ST_LEAD: begin
                if (tmr_q == TMR_W'(STROBE_LEAD - 1)) begin        // [RL6]
                    tmr_d   = '0;
                    state_d = ST_SEND;
                end
            end
            ST_SEND: begin
                if (tmr_q == ph_len - 1'b1) begin
                    tmr_d = '0;
                    unique case (ph_q)
                        PH_SETUP: ph_d = PH_LOW;                   // [RL5]
                        PH_LOW:   ph_d = PH_HIGH;
                        default:  ph_d = PH_SETUP;
                    endcase
                end
                if (slot_end) begin
                    unique case (sect_q)
                        SEC_PRE: begin
                            zcnt_d = zcnt_q + 1'b1;
                            if (zcnt_q == pre_n - 1'b1) begin
                                sect_d = SEC_CHAR;
                            end
                        end
                        SEC_CHAR: begin
                            bpos_d = bpos_q + 1'b1;
                            if (bpos_q == 3'(CHAR_BITS - 1)) begin
                                bpos_d = 3'h0;
                                lrc_d  = lrc_q ^ nib;              // [RL17]
                                cidx_d = cidx_q + 1'b1;
                                if (cidx_q == nchar - 1'b1) begin
                                    zcnt_d = 5'h00;
                                    if (post_n != 5'h00) begin
                                        sect_d = SEC_POST;
                                    end else begin
                                        state_d = stb_en_q ? ST_TRAIL : ST_IDLE;
                                    end
                                end
                            end
                        end
                        default: begin
                            zcnt_d = zcnt_q + 1'b1;
                            if (zcnt_q == post_n - 1'b1) begin
                                state_d = stb_en_q ? ST_TRAIL : ST_IDLE;
                            end
                        end
                    endcase
                end
            end
            default: begin
                if (tmr_q == TMR_W'(STROBE_TRAIL - 1)) begin       // [RL7]
                    state_d = ST_IDLE;
                end
            end
        endcase
        // line enables follow the engine one cycle later, all in step
        link_d.strobe_oe = stb_en_q && (state_q inside {ST_LEAD, ST_SEND, ST_TRAIL}); // [RL1] [RL4]
        link_d.clk_oe    = (state_q == ST_SEND) && (ph_q == PH_LOW);                  // [RL8]
        link_d.data_oe   = (state_q == ST_SEND) && cur_bit;                           // [RL4]
        busy_d           = (state_q != ST_IDLE);                                      // [RL21]
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= ST_IDLE;
            ph_q     <= PH_SETUP;
            sect_q   <= SEC_PRE;
            fmt_q    <= BCDS_FMT_PLAIN;
            stb_en_q <= 1'b0;
            fac_q    <= '0;
            usr_q    <= '0;
            fdig_q   <= '0;
            udig_q   <= '0;
            conv_q   <= 3'h0;
            tmr_q    <= '0;
            zcnt_q   <= 5'h00;
            cidx_q   <= 5'h00;
            bpos_q   <= 3'h0;
            lrc_q    <= 4'h0;
            link_q   <= '0;                                        // [RL22]
            busy_q   <= 1'b0;
        end else if (clk_en) begin
            state_q  <= state_d;
            ph_q     <= ph_d;
            sect_q   <= sect_d;
            fmt_q    <= fmt_d;
            stb_en_q <= stb_en_d;
            fac_q    <= fac_d;
            usr_q    <= usr_d;
            fdig_q   <= fdig_d;
            udig_q   <= udig_d;
            conv_q   <= conv_d;
            tmr_q    <= tmr_d;
            zcnt_q   <= zcnt_d;
            cidx_q   <= cidx_d;
            bpos_q   <= bpos_d;
            lrc_q    <= lrc_d;
            link_q   <= link_d;
            busy_q   <= busy_d;
        end
    end

    // the pins are enables only: a line is pulled low or left to its pull-up
    assign link      = link_q;                                     // [RL3]
    assign req_ready = ready_q;
    assign busy      = busy_q;

    // helper: length of the current clock-low run
    logic [TMR_W-1:0] low_run_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            low_run_q <= '0;
        end else if (clk_en) begin
            low_run_q <= link_q.clk_oe ? low_run_q + 1'b1 : '0;
        end
    end

    AST_IDLE_RELEASED: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [RL22]
        !busy_q |-> (link_q == '0))
        else $error("line pulled low while idle");

    AST_NO_STROBE_WHEN_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL2]
        (busy_q && !stb_en_q && state_q != ST_CONV) |-> !link_q.strobe_oe)
        else $error("strobe asserted while disabled");

    AST_STROBE_IMPLIES_BUSY: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL21]
        link_q.strobe_oe |-> busy_q)
        else $error("strobe asserted while not busy");

    AST_DATA_HELD_LOW_CLK: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL5]
        (link_q.clk_oe && $past(link_q.clk_oe)) || $rose(link_q.clk_oe)
            |-> $stable(link_q.data_oe))
        else $error("data changed around clock low");

    AST_CLK_LOW_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [RL8]
        $fell(link_q.clk_oe) |-> (low_run_q == TMR_W'(LOW_LEN)))
        else $error("clock low phase has wrong length");

    AST_SETUP_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [RL9]
        $rose(link_q.clk_oe) |-> ($past(ph_q, 2) == PH_SETUP)
            && ($past(tmr_q, 2) == TMR_W'(SETUP_LEN - 1)))
        else $error("clock fell before set-up time");

    AST_LEAD_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)    // [RL6]
        ($rose(state_q == ST_SEND) && $past(state_q) == ST_LEAD)
            |-> ($past(tmr_q) == TMR_W'(STROBE_LEAD - 1)) ##1 link_q.strobe_oe)
        else $error("strobe lead time wrong");

    AST_TRAIL_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)   // [RL7]
        ($rose(state_q == ST_IDLE) && $past(state_q) == ST_TRAIL)
            |-> ($past(tmr_q) == TMR_W'(STROBE_TRAIL - 1)) ##1 $fell(link_q.strobe_oe))
        else $error("strobe trail time wrong");

    AST_START_CHAR: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [RL12]
        (state_q == ST_SEND && sect_q == SEC_CHAR && cidx_q == 5'h00) |-> (nib == CHAR_START))
        else $error("first character is not the start character");

    AST_ODD_PARITY: assert property (@(posedge clk_sys) disable iff (!rst_n)  // [RL11]
        (state_q == ST_SEND && sect_q == SEC_CHAR && ph_q == PH_LOW && bpos_q == 3'h4)
            |-> (link_q.data_oe == ~^nib))
        else $error("parity bit does not give odd count");

endmodule : bcds_serializer

`default_nettype wire

//--- testbench/bcds_terminal.sv
`timescale 1ns/10ps
`default_nettype none

module bcds_terminal #(
    parameter int PERIOD = 40
) (
    // time base
    input wire logic clk_sys,
    // link lines after the pull-ups
    input wire logic strobe_line,
    input wire logic clk_line,
    input wire logic data_line
);
    logic q_bits[$];
    logic q_stb[$];
    int   cyc;
    int   t_fall;
    int   t_rise;
    int   t_stb;
    int   lead_cyc;
    int   trail_cyc;
    int   hold_err;
    int   per_err;
    logic data_at_fall;

    initial begin
        cyc = 0;
        hold_err = 0;
        per_err = 0;
        data_at_fall = 1'b1;
    end

    always @(posedge clk_sys) begin
        cyc++;
    end

    // terminal takes a bit on each falling clock line edge; a low data line is a one
    always @(negedge clk_line) begin
        if (q_bits.size() == 0) lead_cyc = cyc - t_stb;
        else if (cyc - t_fall != PERIOD) per_err++;
        t_fall = cyc;
        q_bits.push_back(~data_line);
        q_stb.push_back(~strobe_line);
        data_at_fall = data_line;
    end

    // data must not move while the clock line is low
    always @(posedge clk_line) begin
        t_rise = cyc;
        if (q_bits.size() > 0 && data_line !== data_at_fall) hold_err++;
    end

    always @(negedge strobe_line) begin
        t_stb = cyc;
    end

    always @(posedge strobe_line) begin
        trail_cyc = cyc - t_rise;
    end
endmodule : bcds_terminal

`default_nettype wire

//--- testbench/test_badge_clock_data_serializer.sv
`timescale 1ns/10ps
`default_nettype none

module test_badge_clock_data_serializer;
    import bcds_pkg::*;
    // short counts keep the run small
    localparam int BP = 40;
    localparam int SL = 200;
    localparam int ST = 200;

    typedef struct packed {
        bcds_fmt_e        fmt;
        logic             stb;
        logic [FAC_W-1:0] fac;
        logic [USR_W-1:0] usr;
    } bcds_row_s;

    logic       clk_sys = 1'b0;
    logic       rst_n = 1'b0;
    logic       clk_en = 1'b1;
    bcds_fmt_e  cfg_fmt = BCDS_FMT_PLAIN;
    logic       cfg_strobe_en = 1'b0;
    logic       req_valid = 1'b0;
    bcds_req_s  req = '0;
    logic       req_ready;
    logic       busy;
    bcds_link_s link;
    wire logic  strobe_line;
    wire logic  clk_line;
    wire logic  data_line;
    int         error_cnt = 0;
    int         num_checks = 0;
    int         cyc_cnt = 0;
    bcds_link_s held;

    // open-drain lines with pull-ups: never driven high
    assign strobe_line = link.strobe_oe ? 1'b0 : 1'b1;
    assign clk_line    = link.clk_oe ? 1'b0 : 1'b1;
    assign data_line   = link.data_oe ? 1'b0 : 1'b1;

    bcds_row_s rows [5] = '{
        '{BCDS_FMT_PLAIN, 1'b1, 17'd563, 20'd3551},
        '{BCDS_FMT_LRC, 1'b0, 17'd99999, 20'd99999},
        '{BCDS_FMT_LONG, 1'b1, 17'd9999, 20'd999999},
        '{BCDS_FMT_LONG, 1'b0, 17'd12345, 20'd1048575},
        '{BCDS_FMT_PLAIN, 1'b0, 17'd0, 20'd0}
    };
    bcds_row_s b2b [4] = '{
        '{BCDS_FMT_LRC, 1'b1, 17'd1, 20'd2},
        '{BCDS_FMT_LRC, 1'b1, 17'd70615, 20'd48213},
        '{BCDS_FMT_LRC, 1'b1, 17'd80000, 20'd9},
        '{BCDS_FMT_LRC, 1'b1, 17'd11111, 20'd22222}
    };

    bcds_serializer #(
        .BIT_PERIOD  (BP),
        .STROBE_LEAD (SL),
        .STROBE_TRAIL(ST)
    ) u_bcds_serializer (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .clk_en       (clk_en),
        .cfg_fmt      (cfg_fmt),
        .cfg_strobe_en(cfg_strobe_en),
        .req_valid    (req_valid),
        .req          (req),
        .req_ready    (req_ready),
        .busy         (busy),
        .link         (link)
    );

    // the terminal's default period matches BP
    bcds_terminal u_bcds_terminal (
        .clk_sys    (clk_sys),
        .strobe_line(strobe_line),
        .clk_line   (clk_line),
        .data_line  (data_line)
    );

    always #20 clk_sys = ~clk_sys;

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 60000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // whole expected bit stream, worked out digit by digit
    function automatic void build_bits(input bcds_row_s r, ref logic q[$]);
        logic [3:0] c[$];
        logic [3:0] l;
        int nf, nu, pre;
        nf = (r.fmt == BCDS_FMT_LONG) ? 4 : 5;
        nu = (r.fmt == BCDS_FMT_LONG) ? 6 : 5;
        pre = (r.fmt == BCDS_FMT_PLAIN) ? 0 : (r.fmt == BCDS_FMT_LRC) ? 10 : 15;
        c.push_back(4'hB);
        if (r.fmt == BCDS_FMT_LONG) for (int i = 7; i >= 0; i--) c.push_back(4'(32'h1A210001 >> (4 * i)));
        for (int i = nf - 1; i >= 0; i--) c.push_back(4'((int'(r.fac) / (10 ** i)) % 10));
        if (r.fmt == BCDS_FMT_LONG) begin
            c.push_back(4'h0);
            c.push_back(4'h1);
        end
        for (int i = nu - 1; i >= 0; i--) c.push_back(4'((int'(r.usr) / (10 ** i)) % 10));
        c.push_back(4'hF);
        l = 4'h0;
        foreach (c[k]) l ^= c[k];
        if (r.fmt != BCDS_FMT_PLAIN) c.push_back(l);
        q.delete();
        repeat (pre) q.push_back(1'b0);
        foreach (c[k]) begin
            for (int b = 0; b < 4; b++) q.push_back(c[k][b]);
            q.push_back(~^c[k]);
        end
        if (r.fmt == BCDS_FMT_LONG) repeat (15) q.push_back(1'b0);
    endfunction : build_bits

    task automatic clear_cap;
        u_bcds_terminal.q_bits.delete();
        u_bcds_terminal.q_stb.delete();
        u_bcds_terminal.hold_err = 0;
        u_bcds_terminal.per_err = 0;
    endtask : clear_cap

    task automatic push_req(input bcds_row_s r);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 1000) begin
            @(negedge clk_sys);
            n++;
        end
        cfg_fmt = r.fmt;
        cfg_strobe_en = r.stb;
        req = '{r.fac, r.usr};
        req_valid = 1'b1;
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask : push_req

    task automatic expect_msg(input bcds_row_s r);
        logic e[$];
        logic ok;
        int n;
        build_bits(r, e);
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        while (busy !== 1'b0 && n < 20000) begin
            @(negedge clk_sys);
            n++;
        end
        check(busy, 1'b0);
        check(u_bcds_terminal.q_bits.size(), e.size());
        for (int i = 0; i < e.size() && i < u_bcds_terminal.q_bits.size(); i++)
            check(u_bcds_terminal.q_bits[i], e[i]);
        for (int i = 0; i < u_bcds_terminal.q_stb.size(); i++)
            check(u_bcds_terminal.q_stb[i], r.stb);
        if (r.stb) begin
            ok = u_bcds_terminal.lead_cyc >= SL && u_bcds_terminal.lead_cyc <= SL + BP;
            check(ok, 1'b1);
            ok = u_bcds_terminal.trail_cyc >= ST && u_bcds_terminal.trail_cyc <= ST + BP;
            check(ok, 1'b1);
        end
        check(u_bcds_terminal.hold_err, 0);
        check(u_bcds_terminal.per_err, 0);
        check(link, 3'b000);
        clear_cap();
    endtask : expect_msg

    initial begin
        repeat (6) @(negedge clk_sys);
        check(link, 3'b000);
        check(req_ready, 1'b1);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            push_req(rows[i]);
            expect_msg(rows[i]);
        end
        // fill the buffer back to back; a fourth request must be refused
        cfg_fmt = BCDS_FMT_LRC;
        cfg_strobe_en = 1'b1;
        req_valid = 1'b1;
        for (int i = 0; i < 3; i++) begin
            req = '{b2b[i].fac, b2b[i].usr};
            @(negedge clk_sys);
        end
        check(req_ready, 1'b0);
        req = '{b2b[3].fac, b2b[3].usr};
        repeat (4) @(negedge clk_sys);
        req_valid = 1'b0;
        for (int i = 0; i < 3; i++) expect_msg(b2b[i]);
        repeat (50) @(negedge clk_sys);
        check(busy, 1'b0);
        check(u_bcds_terminal.q_bits.size(), 0);
        // freeze in mid-message, then reset in mid-message
        push_req(rows[2]);
        repeat (400) @(negedge clk_sys);
        clk_en = 1'b0;
        held = link;
        repeat (30) @(negedge clk_sys);
        check(link, held);
        check(busy, 1'b1);
        clk_en = 1'b1;
        repeat (100) @(negedge clk_sys);
        rst_n = 1'b0;
        @(negedge clk_sys);
        check(link, 3'b000);
        check(busy, 1'b0);
        check(req_ready, 1'b1);
        rst_n = 1'b1;
        clear_cap();
        push_req(rows[0]);
        expect_msg(rows[0]);
        conclude();
    end
endmodule : test_badge_clock_data_serializer

`default_nettype wire
